// ---- bench/chan_partner.sv ----
// Behavioural device controller and memory port facing the sequencer
`timescale 1ns/1ps
module chan_partner
  import chan_pkg::*;
#(
  parameter logic [DW-1:0] STAT = 16'h3c5a
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          channel_service_out,
  input  wire logic          programmed_write_strobe,
  input  wire logic          programmed_status_strobe,
  input  wire logic          programmed_set_interrupt,
  input  wire logic          end_of_transfer,
  input  wire logic [DW-1:0] chan_data_out,
  input  wire logic          read_restore_request,
  input  wire logic          clear_write_request,
  input  wire logic [TMC_W-1:0] target_module_code,
  input  wire logic [DW-1:0] port_bus_out,
  output logic               channel_service_request,
  output logic               channel_acknowledge,
  output logic      [DW-1:0] chan_data_in,
  output logic               low_select_grant,
  output logic               high_select_grant,
  output logic               memory_data_strobe,
  output logic      [DW-1:0] port_bus_in
);
  logic [DW-1:0] words[$];
  logic [31:0]   wlog[$];
  int            ints;
  int            stats;
  logic [TMC_W-1:0] tlog[$];
  int            eots;
  int            ph;
  logic          wstb_q;
  logic          wr;
  logic [DW-1:0] addr;
  // Status only valid while acknowledging; inverse otherwise
  assign chan_data_in = channel_acknowledge ? STAT : ~STAT;
  // ****************************************************
  // Controller handshake and memory port
  // ****************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_service_request <= 1'b0;
      channel_acknowledge <= 1'b0;
      low_select_grant <= 1'b0;
      high_select_grant <= 1'b0;
      memory_data_strobe <= 1'b0;
      port_bus_in <= 16'hffff;
      wstb_q <= 1'b0;
      wr <= 1'b0;
      addr <= 16'h0000;
      ph <= 0;
      ints <= 0;
      stats <= 0;
      eots <= 0;
    end else begin
      channel_acknowledge <= channel_service_out;
      // Re-arm only once service out and acknowledge are both down
      channel_service_request <= !channel_service_out &&
                                 !channel_acknowledge;
      wstb_q <= programmed_write_strobe;
      if (wstb_q && !programmed_write_strobe) begin
        words.push_back(chan_data_out);
      end
      if (channel_service_out && programmed_set_interrupt &&
          !channel_acknowledge) begin
        ints <= ints + 1;
      end
      if (channel_service_out && programmed_status_strobe &&
          !channel_acknowledge) begin
        stats <= stats + 1;
      end
      if (end_of_transfer) begin
        eots <= eots + 1;
      end
      low_select_grant <= 1'b0;
      high_select_grant <= 1'b0;
      memory_data_strobe <= 1'b0;
      case (ph)
        0: if (read_restore_request || clear_write_request) begin
          low_select_grant <= 1'b1;
          tlog.push_back(target_module_code);
          wr <= clear_write_request;
          ph <= 1;
        end
        1: ph <= 2;
        2: begin
          addr <= port_bus_out;
          high_select_grant <= wr;
          memory_data_strobe <= !wr;
          port_bus_in <= port_bus_out + 16'h1000;
          ph <= wr ? 3 : 4;
        end
        3: ph <= 5;
        4: begin
          port_bus_in <= ~port_bus_in;
          ph <= 0;
        end
        default: begin
          wlog.push_back({addr, port_bus_out});
          ph <= 0;
        end
      endcase
    end
  end
endmodule // chan_partner

// ---- bench/channel_write_end_sequencer_tb.sv ----
// Self-checking bench for the write and end order sequencer
`timescale 1ns/1ps
module channel_write_end_sequencer_tb;
  import chan_pkg::*;
  localparam logic [DW-1:0] ST = 16'h3c5a;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, device_end;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic channel_service_request, channel_acknowledge, channel_service_out;
  logic programmed_write_strobe, programmed_set_interrupt, end_of_transfer;
  logic read_restore_request, clear_write_request, err;
  logic low_select_grant, high_select_grant, memory_data_strobe;
  logic [DW-1:0] chan_data_in, chan_data_out, port_bus_out, port_bus_in;
  logic programmed_status_strobe;
  logic [TMC_W-1:0] target_module_code;
  int bad_count, checked, i;
  chan_write_end u_chan_write_end (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .channel_service_request, .channel_acknowledge, .device_end,
    .chan_data_in, .channel_service_out, .programmed_write_strobe,
    .programmed_status_strobe, .programmed_set_interrupt,
    .end_of_transfer, .chan_data_out, .read_restore_request,
    .clear_write_request, .target_module_code, .port_bus_out,
    .low_select_grant, .high_select_grant, .memory_data_strobe,
    .port_bus_in);
  chan_partner #(.STAT(ST)) u_chan_partner (.pclk, .presetn,
    .channel_service_out, .programmed_write_strobe,
    .programmed_status_strobe, .target_module_code,
    .programmed_set_interrupt, .end_of_transfer, .chan_data_out,
    .read_restore_request, .clear_write_request, .port_bus_out,
    .channel_service_request, .channel_acknowledge, .chan_data_in,
    .low_select_grant, .high_select_grant, .memory_data_strobe,
    .port_bus_in);
  // ****************************************************
  // Shared tasks
  // ****************************************************
  task print_verdict;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tmo;
    bad_count++;
    $display("unexpected at %0t: got %h expected %h", $time, 0, 1);
    print_verdict;
  endtask
  task apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (k == 20) tmo;
  endtask
  task wait_idle;
    for (i = 0; i < 200; i++) begin
      apb(1'b0, OFF_STATUS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (i == 200) tmo;
  endtask
  // ****************************************************
  // Scenarios
  // ****************************************************
  task t_reset;
    apb(1'b0, OFF_STATUS, 32'h0);
    cmp(rd, 32'h0);
    apb(1'b0, OFF_CW, 32'h0);
    cmp(rd, {16'h0000, RST_WORD});
    apb(1'b0, 8'h24, 32'h0);
    cmp({31'h0, err}, 32'h1);
    $display("test reset done");
  endtask
  task t_write;
    u_chan_partner.words.delete();
    apb(1'b1, OFF_CW, 32'h0000ffd0);
    apb(1'b1, OFF_AW, 32'h00000040);
    apb(1'b1, OFF_CMD, 32'h1);
    for (i = 0; i < 3000 && u_chan_partner.eots < 1; i++) @(posedge pclk);
    if (i == 3000) tmo;
    wait_idle;
    cmp(u_chan_partner.words.size(), 3);
    for (i = 0; i < 3; i++) cmp(u_chan_partner.words[i], 16'h1040 + i);
    cmp(u_chan_partner.eots, 1);
    cmp(rd[3:0], 4'h8);
    apb(1'b0, OFF_CW, 32'h0);
    cmp(rd, 32'h0);
    apb(1'b1, OFF_CMD, 32'h4);
    apb(1'b0, OFF_STATUS, 32'h0);
    cmp(rd[3], 1'b0);
    $display("test write done");
  endtask
  task t_chain;
    u_chan_partner.words.delete();
    u_chan_partner.tlog.delete();
    apb(1'b1, OFF_CW, 32'h0000ffe1);
    apb(1'b1, OFF_AW, 32'h00000080);
    apb(1'b1, OFF_NCW, 32'h0000fff0);
    apb(1'b1, OFF_NAW, 32'h0000a090);
    apb(1'b1, OFF_CMD, 32'h1);
    for (i = 0; i < 3000 && u_chan_partner.eots < 3; i++) @(posedge pclk);
    if (i == 3000) tmo;
    wait_idle;
    cmp(u_chan_partner.words.size(), 3);
    cmp(u_chan_partner.words[0], 16'h1080);
    cmp(u_chan_partner.words[1], 16'h1081);
    cmp(u_chan_partner.words[2], 16'hb090);
    cmp(u_chan_partner.tlog[2], 32'h5);
    $display("test chain done");
  endtask
  task t_dend;
    u_chan_partner.words.delete();
    apb(1'b1, OFF_CW, 32'h0000f000);
    apb(1'b1, OFF_AW, 32'h00000200);
    apb(1'b1, OFF_CMD, 32'h1);
    for (i = 0; i < 3000 && u_chan_partner.words.size() < 2; i++)
      @(posedge pclk);
    if (i == 3000) tmo;
    device_end <= 1'b1;
    for (i = 0; i < 3000 && u_chan_partner.eots < 4; i++) @(posedge pclk);
    if (i == 3000) tmo;
    device_end <= 1'b0;
    wait_idle;
    cmp(u_chan_partner.eots, 4);
    cmp(rd[1], 1'b0);
    for (i = 0; i < u_chan_partner.words.size(); i++)
      cmp(u_chan_partner.words[i], 16'h1200 + i);
    apb(1'b0, OFF_CW, 32'h0);
    cmp(rd[15:4], 12'hf00 + u_chan_partner.words.size());
    $display("test device end done");
  endtask
  task t_end;
    apb(1'b1, OFF_CMD, 32'h4);
    apb(1'b1, OFF_CW, 32'h00000010);
    apb(1'b1, OFF_PC, 32'h00000100);
    apb(1'b1, OFF_DEVICE_NUMBER, 32'h00000005);
    apb(1'b1, OFF_CMD, 32'h2);
    for (i = 0; i < 3000 && u_chan_partner.wlog.size() < 2; i++)
      @(posedge pclk);
    if (i == 3000) tmo;
    wait_idle;
    cmp(u_chan_partner.wlog[0], {16'h00ff, ST});
    cmp(u_chan_partner.wlog[1], 32'h00140100);
    cmp(u_chan_partner.ints, 1);
    cmp(u_chan_partner.stats, 1);
    apb(1'b0, OFF_DSTAT, 32'h0);
    cmp(rd, {16'h0000, ST});
    apb(1'b1, OFF_CW, 32'h00000000);
    apb(1'b1, OFF_CMD, 32'h2);
    for (i = 0; i < 3000 && u_chan_partner.wlog.size() < 4; i++)
      @(posedge pclk);
    if (i == 3000) tmo;
    wait_idle;
    cmp(u_chan_partner.ints, 1);
    cmp(u_chan_partner.stats, 2);
    cmp(u_chan_partner.wlog[3], 32'h00140100);
    $display("test end done");
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, device_end} = 5'b0;
    paddr = '0;
    pwdata = '0;
    bad_count = 0;
    checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_write;
    t_chain;
    t_dend;
    t_end;
    print_verdict;
  end
endmodule // channel_write_end_sequencer_tb

// ---- inc/chan_pkg.sv ----
// Constants, offsets and types shared by the write/end order sequencer
package chan_pkg;
  localparam int DW          = 16;
  localparam int CNT_LSB     = 4;
  localparam int CNT_MSB     = 15;
  localparam int CNT_W       = CNT_MSB - CNT_LSB + 1;
  localparam int CHAIN_BIT   = 0;
  localparam int INT_BIT     = 4;
  localparam int TMC_W       = 3;
  localparam int DEVICE_NUMBER_W     = 8;
  localparam int DRT_SHIFT   = 2;
  localparam int AW          = 8;
  localparam int SYNC_W      = 3 + DW;
  // Register byte offsets
  localparam logic [AW-1:0] OFF_CMD     = 8'h00;
  localparam logic [AW-1:0] OFF_CW      = 8'h04;
  localparam logic [AW-1:0] OFF_AW      = 8'h08;
  localparam logic [AW-1:0] OFF_NCW     = 8'h0c;
  localparam logic [AW-1:0] OFF_NAW     = 8'h10;
  localparam logic [AW-1:0] OFF_DEVICE_NUMBER   = 8'h14;
  localparam logic [AW-1:0] OFF_PC      = 8'h18;
  localparam logic [AW-1:0] OFF_STATUS  = 8'h1c;
  localparam logic [AW-1:0] OFF_DSTAT   = 8'h20;
  // Command bits
  localparam int CMD_WRITE   = 0;
  localparam int CMD_END     = 1;
  localparam int CMD_OFCLR   = 2;
  // Reset values
  localparam logic [DW-1:0] RST_WORD    = 16'h0000;
  localparam logic [DEVICE_NUMBER_W-1:0] RST_DEVICE_NUMBER = 8'h00;
  typedef enum logic [4:0] {
    ST_IDLE, ST_WR_START, ST_WR_ACKLO, ST_XFER, ST_STB, ST_DROP,
    ST_INC, ST_REL, ST_EOT, ST_WAIT_SR, ST_END_STAT, ST_END_SREL,
    ST_END_INT, ST_END_IREL, ST_END_W1, ST_END_W2
  } state_t;
  typedef enum logic [2:0] {
    M_IDLE, M_RD_REQ, M_RD_DATA, M_WR_REQ, M_WR_DATA, M_WR_DONE
  } mstate_t;
endpackage

// ---- src/chan_write_end.sv ----
// Write and end order sequencer of a high-speed I/O channel
`timescale 1ns/1ps
module chan_write_end
  import chan_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [chan_pkg::AW-1:0] paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 channel_service_request,
  input  wire logic                 channel_acknowledge,
  input  wire logic                 device_end,
  input  wire logic [chan_pkg::DW-1:0] chan_data_in,
  output logic                      channel_service_out,
  output logic                      programmed_write_strobe,
  output logic                      programmed_status_strobe,
  output logic                      programmed_set_interrupt,
  output logic                      end_of_transfer,
  output logic      [chan_pkg::DW-1:0] chan_data_out,
  output logic                      read_restore_request,
  output logic                      clear_write_request,
  output logic      [chan_pkg::TMC_W-1:0] target_module_code,
  output logic      [chan_pkg::DW-1:0] port_bus_out,
  input  wire logic                 low_select_grant,
  input  wire logic                 high_select_grant,
  input  wire logic                 memory_data_strobe,
  input  wire logic [chan_pkg::DW-1:0] port_bus_in
);
  import chan_pkg::*;

  // ******************************************************
  // Input synchronisation and APB slave
  // ******************************************************
  logic [SYNC_W-1:0] sync_q;
  logic              sr_s, ack_s, dend_s;
  logic [DW-1:0]     din_s;

  sync2 #(.W(SYNC_W)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({channel_service_request, channel_acknowledge,
               device_end, chan_data_in}),
    .q       (sync_q)
  );
  assign {sr_s, ack_s, dend_s, din_s} = sync_q;

  logic [31:0] prdata_nxt, rd_mux;
  logic        pready_nxt, pslverr_nxt, hit, wr_en;
  state_t      st_r, st_nxt;
  mstate_t     ms_r, ms_nxt;
  logic [DW-1:0] cw_r, cw_nxt, aw_r, aw_nxt, ncw_r, ncw_nxt;
  logic [DW-1:0] naw_r, naw_nxt, pc_r, pc_nxt, stat_r, stat_nxt;
  logic [DEVICE_NUMBER_W-1:0] device_number_r, device_number_nxt;
  logic          nval_r, nval_nxt, oxf_r, oxf_nxt, ofetch_r, ofetch_nxt;
  logic          roll_r, roll_nxt, fdone_r, fdone_nxt;
  logic [CNT_W-1:0] fc_r, fc_nxt;
  logic [DW-1:0] buf_r [2];
  logic [DW-1:0] buf_nxt [2];
  logic          wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0]    bcnt_r, bcnt_nxt;

  always_comb begin
    hit = 1'b1;
    rd_mux = '0;
    case (paddr)
      OFF_CMD, OFF_STATUS: rd_mux = {24'h0, fdone_r, roll_r, bcnt_r,
                                     ofetch_r, nval_r, oxf_r,
                                     st_r != ST_IDLE};
      OFF_CW:    rd_mux = {16'h0, cw_r};
      OFF_AW:    rd_mux = {16'h0, aw_r};
      OFF_NCW:   rd_mux = {16'h0, ncw_r};
      OFF_NAW:   rd_mux = {16'h0, naw_r};
      OFF_DEVICE_NUMBER: rd_mux = {24'h0, device_number_r};
      OFF_PC:    rd_mux = {16'h0, pc_r};
      OFF_DSTAT: rd_mux = {16'h0, stat_r};
      default:   hit = 1'b0;
    endcase
    // No wait state: answer is prepared in the setup cycle
    pready_nxt  = psel & ~penable;
    prdata_nxt  = (psel & ~penable & ~pwrite) ? rd_mux : 32'h0;
    pslverr_nxt = psel & ~penable & ~hit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= pready_nxt;
      prdata  <= prdata_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  assign wr_en = psel & penable & pready & pwrite & hit;

  // ******************************************************
  // Order sequencer and memory port
  // ******************************************************
  function automatic logic [TMC_W-1:0] tmc_f(input logic [DW-1:0] a);
    return a[DW-1 -: TMC_W];
  endfunction

  logic [DW-1:0] waddr, wdata;
  logic [CNT_W:0] wc_inc, fc_inc;
  logic so_n, wstb_n, sstb_n, sint_n, eot_n, rr_n, cwr_n;
  logic [TMC_W-1:0] tmc_n;
  logic [DW-1:0] cdo_n, pbo_n;
  logic push, pop, idle_cmd;

  always_comb begin
    st_nxt = st_r;
    ms_nxt = ms_r;
    cw_nxt = cw_r;
    aw_nxt = aw_r;
    ncw_nxt = ncw_r;
    naw_nxt = naw_r;
    pc_nxt = pc_r;
    stat_nxt = stat_r;
    device_number_nxt = device_number_r;
    nval_nxt = nval_r;
    oxf_nxt = oxf_r;
    ofetch_nxt = ofetch_r;
    roll_nxt = roll_r;
    fdone_nxt = fdone_r;
    fc_nxt = fc_r;
    buf_nxt = buf_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cdo_n = chan_data_out;
    pbo_n = port_bus_out;
    tmc_n = target_module_code;
    push = 1'b0;
    pop = 1'b0;
    idle_cmd = (st_r == ST_IDLE) && wr_en && (paddr == OFF_CMD);
    waddr = (st_r == ST_END_W1) ? pc_r - 16'h0001
          : DW'({device_number_r, {DRT_SHIFT{1'b0}}});
    wdata = (st_r == ST_END_W1) ? stat_r : pc_r;
    wc_inc = {1'b0, cw_r[CNT_MSB:CNT_LSB]} + 13'h0001;
    fc_inc = {1'b0, fc_r} + 13'h0001;
    // Control word, address word, device number and PC writes land only while the channel is idle
    if (wr_en && st_r == ST_IDLE) begin
      case (paddr)
        OFF_CW:    cw_nxt = pwdata[DW-1:0];
        OFF_AW:    aw_nxt = pwdata[DW-1:0];
        OFF_DEVICE_NUMBER: device_number_nxt = pwdata[DEVICE_NUMBER_W-1:0];
        OFF_PC:    pc_nxt = pwdata[DW-1:0];
        default: ;
      endcase
    end
    // Holding pair may be refilled during a block
    if (wr_en && paddr == OFF_NCW) ncw_nxt = pwdata[DW-1:0];
    if (wr_en && paddr == OFF_NAW) begin
      naw_nxt = pwdata[DW-1:0];
      nval_nxt = 1'b1;
    end
    if (wr_en && paddr == OFF_CMD && pwdata[CMD_OFCLR])
      ofetch_nxt = 1'b0;
    case (st_r)
      ST_IDLE: begin
        if (idle_cmd && pwdata[CMD_WRITE]) begin
          st_nxt = ST_WR_START;
          fc_nxt = cw_r[CNT_MSB:CNT_LSB];
          roll_nxt = 1'b0;
          fdone_nxt = 1'b0;
        end else if (idle_cmd && pwdata[CMD_END]) begin
          st_nxt = ST_END_STAT;
        end
      end
      ST_WR_START: if (ack_s) st_nxt = ST_WR_ACKLO;
      ST_WR_ACKLO: begin
        oxf_nxt = 1'b1;
        if (!ack_s) st_nxt = ST_XFER;
      end
      ST_XFER: begin
        if ((dend_s || roll_r) && ms_r == M_IDLE)
          st_nxt = ST_EOT;
        else if (sr_s && !ack_s && bcnt_r != 2'd0 && !roll_r) begin
          st_nxt = ST_STB;
          cdo_n = buf_r[rp_r];
        end
      end
      ST_STB: if (ack_s) begin
        st_nxt = ST_DROP;
        pop = 1'b1;
      end
      ST_DROP: begin
        st_nxt = ST_INC;
        cw_nxt[CNT_MSB:CNT_LSB] = wc_inc[CNT_W-1:0];
        if (wc_inc[CNT_W]) roll_nxt = 1'b1;
      end
      ST_INC: st_nxt = ST_REL;
      ST_REL: if (!ack_s) st_nxt = ST_XFER;
      ST_EOT: begin
        roll_nxt = 1'b0;
        wp_nxt = 1'b0;
        rp_nxt = 1'b0;
        if (cw_r[CHAIN_BIT] && nval_r) begin
          // Chained pair replaces the active pair with no fetch cycle
          cw_nxt = ncw_r;
          aw_nxt = naw_r;
          fc_nxt = ncw_r[CNT_MSB:CNT_LSB];
          fdone_nxt = 1'b0;
          // A holding address word write in this very cycle keeps the flag set
          nval_nxt = wr_en && paddr == OFF_NAW;
          st_nxt = ST_XFER;
        end else begin
          oxf_nxt = 1'b0;
          st_nxt = ST_WAIT_SR;
        end
      end
      ST_WAIT_SR: if (sr_s) begin
        st_nxt = ST_IDLE;
        ofetch_nxt = 1'b1;
      end
      ST_END_STAT: if (ack_s) begin
        stat_nxt = din_s;
        st_nxt = ST_END_SREL;
      end
      ST_END_SREL: begin
        // Keep latching while acknowledge stays high: status bits and acknowledge pass
        // separate flip-flops, so the first sample may be skewed
        if (ack_s) stat_nxt = din_s;
        else st_nxt = cw_r[INT_BIT] ? ST_END_INT : ST_END_W1;
      end
      ST_END_INT: if (ack_s) st_nxt = ST_END_IREL;
      ST_END_IREL: if (!ack_s) st_nxt = ST_END_W1;
      ST_END_W1: if (ms_r == M_WR_DONE) st_nxt = ST_END_W2;
      ST_END_W2: if (ms_r == M_WR_DONE) st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
    case (ms_r)
      M_IDLE: begin
        if (oxf_r && st_r != ST_EOT && !fdone_r && !dend_s
            && bcnt_r != 2'd2) begin
          ms_nxt = M_RD_REQ;
          tmc_n = tmc_f(aw_r);
        end else if (st_r == ST_END_W1 || st_r == ST_END_W2) begin
          ms_nxt = M_WR_REQ;
          tmc_n = tmc_f(waddr);
        end
      end
      M_RD_REQ: if (low_select_grant) begin
        pbo_n = aw_r;
        aw_nxt = aw_r + 16'h0001;
        fc_nxt = fc_inc[CNT_W-1:0];
        if (fc_inc[CNT_W]) fdone_nxt = 1'b1;
        ms_nxt = M_RD_DATA;
      end
      M_RD_DATA: if (memory_data_strobe) begin
        push = 1'b1;
        ms_nxt = M_IDLE;
      end
      M_WR_REQ: if (low_select_grant) begin
        pbo_n = waddr;
        ms_nxt = M_WR_DATA;
      end
      M_WR_DATA: if (high_select_grant) begin
        pbo_n = wdata;
        ms_nxt = M_WR_DONE;
      end
      M_WR_DONE: ms_nxt = M_IDLE;
      default: ms_nxt = M_IDLE;
    endcase
    if (push) begin
      buf_nxt[wp_r] = port_bus_in;
      wp_nxt = ~wp_r;
    end
    if (pop) rp_nxt = ~rp_r;
    bcnt_nxt = (st_r == ST_EOT) ? 2'd0
             : bcnt_r + {1'b0, push} - {1'b0, pop};
    so_n = st_nxt inside {ST_WR_START, ST_STB, ST_DROP, ST_INC,
                          ST_END_STAT, ST_END_INT};
    wstb_n = st_nxt == ST_STB;
    sstb_n = st_nxt == ST_END_STAT;
    sint_n = st_nxt == ST_END_INT;
    eot_n = st_nxt == ST_EOT;
    rr_n = ms_nxt == M_RD_REQ;
    cwr_n = ms_nxt == M_WR_REQ;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
      ms_r <= M_IDLE;
      cw_r <= RST_WORD;
      aw_r <= RST_WORD;
      ncw_r <= RST_WORD;
      naw_r <= RST_WORD;
      pc_r <= RST_WORD;
      stat_r <= RST_WORD;
      device_number_r <= RST_DEVICE_NUMBER;
      {nval_r, oxf_r, ofetch_r, roll_r, fdone_r} <= 5'h00;
      fc_r <= '0;
      buf_r <= '{RST_WORD, RST_WORD};
      {wp_r, rp_r} <= 2'h0;
      bcnt_r <= 2'h0;
      {channel_service_out, programmed_write_strobe} <= 2'h0;
      {programmed_status_strobe, programmed_set_interrupt} <= 2'h0;
      {end_of_transfer, read_restore_request} <= 2'h0;
      clear_write_request <= 1'b0;
      target_module_code <= '0;
      chan_data_out <= RST_WORD;
      port_bus_out <= RST_WORD;
    end else begin
      st_r <= st_nxt;
      ms_r <= ms_nxt;
      cw_r <= cw_nxt;
      aw_r <= aw_nxt;
      ncw_r <= ncw_nxt;
      naw_r <= naw_nxt;
      pc_r <= pc_nxt;
      stat_r <= stat_nxt;
      device_number_r <= device_number_nxt;
      {nval_r, oxf_r, ofetch_r, roll_r, fdone_r} <=
        {nval_nxt, oxf_nxt, ofetch_nxt, roll_nxt, fdone_nxt};
      fc_r <= fc_nxt;
      buf_r <= buf_nxt;
      {wp_r, rp_r} <= {wp_nxt, rp_nxt};
      bcnt_r <= bcnt_nxt;
      {channel_service_out, programmed_write_strobe} <= {so_n, wstb_n};
      {programmed_status_strobe, programmed_set_interrupt} <=
        {sstb_n, sint_n};
      {end_of_transfer, read_restore_request} <= {eot_n, rr_n};
      clear_write_request <= cwr_n;
      target_module_code <= tmc_n;
      chan_data_out <= cdo_n;
      port_bus_out <= pbo_n;
    end
  end

  // ******************************************************
  // Assertions
  // ******************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_START_ACK: assert property (
    st_r == ST_WR_START && ack_s |=> ##1 oxf_r)
    else $error("out-transfer not entered after acknowledge");
  AST_FETCH_TMC: assert property (
    read_restore_request |-> target_module_code == tmc_f(aw_r))
    else $error("fetch target code does not match address word");
  AST_ADDR_INC: assert property (
    ms_r == M_RD_REQ && low_select_grant
    |=> port_bus_out == $past(aw_r) && aw_r == $past(aw_r) + 16'h0001)
    else $error("address word not driven then incremented");
  AST_FILL: assert property (
    ms_r == M_RD_DATA && memory_data_strobe && !pop
    |=> bcnt_r == $past(bcnt_r) + 2'd1)
    else $error("memory word not captured into a buffer");
  AST_ACK_ORDER: assert property (
    st_r == ST_STB && ack_s |=> channel_service_out
    && !programmed_write_strobe ##1 channel_service_out
    ##1 !channel_service_out)
    else $error("strobe, count, service out not released in order");
  AST_EOT: assert property (
    st_r == ST_XFER && roll_r && ms_r == M_IDLE
    |=> end_of_transfer ##1 (oxf_r != !cw_r[CHAIN_BIT] || nval_r
    || st_r == ST_XFER))
    else $error("end of transfer missing after rollover");
  AST_WAIT_SR: assert property (
    st_r == ST_WAIT_SR && !sr_s |=> st_r == ST_WAIT_SR && !oxf_r)
    else $error("left end state without service request");
  AST_INT_BIT: assert property (
    $rose(programmed_set_interrupt) |-> cw_r[INT_BIT])
    else $error("set interrupt without control bit 4");
  AST_DRT_ADDR: assert property (
    st_r == ST_END_W2 && ms_r == M_WR_REQ && low_select_grant
    |=> port_bus_out == DW'({device_number_r, 2'b00}))
    else $error("table address is not device number times four");
  AST_TO_IDLE: assert property (
    st_r == ST_END_W2 && ms_r == M_WR_DONE |=> st_r == ST_IDLE)
    else $error("channel not inactive after table write");
  AST_NO_EMPTY: assert property (
    $rose(programmed_write_strobe) |-> $past(bcnt_r) != 2'd0)
    else $error("write strobe raised with both buffers empty");

  COV_WORD: cover property (st_r == ST_STB && ack_s);
  COV_CHAIN: cover property (st_r == ST_EOT && cw_r[CHAIN_BIT]
                             && nval_r);
  COV_END: cover property (st_r == ST_END_W2 && ms_r == M_WR_DONE);
endmodule // chan_write_end

// ---- src/sync2.sv ----
// Two flip-flop synchroniser for a group of level inputs
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // sync2
